// ==== rtl/dct_pkg.sv ====
// package for the dual counter/timer: layouts, encodings, reset values
package dct_pkg;
	// ==========================================================
	// timer mode encodings (two mode-select bits per timer)
	localparam logic [1:0] MODE_13BIT = 2'h0;
	localparam logic [1:0] MODE_16BIT = 2'h1;
	localparam logic [1:0] MODE_8RELOAD = 2'h2;
	localparam logic [1:0] MODE_SPLIT = 2'h3;
	// ==========================================================
	// prescale field encodings (divide values are parameters of the top)
	localparam int PRESCALE_SEL_W = 2;
	// ==========================================================
	// reset values and prescaler count width
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam logic [1:0] SYNC_RESET = 2'h0;
	localparam int PRESCALE_CNT_W = 8;
	// 13-bit mode: low byte keeps five count bits
	localparam int LOW13_BITS = 5;
	localparam logic [7:0] LOW13_MASK = 8'h1F;

	// per-timer configuration taken from the mode/control registers
	typedef struct packed {
		logic run;            // run bit of the control register
		logic gateEnable;     // gate-enable bit of the mode register
		logic counterSelect;  // 1: count pin, 0: internal clock
		logic clockSelect;    // 1: system clock, 0: prescaled clock
		logic gatePolarity;   // 1: gate active high
		logic irqEnable;      // overflow interrupt enable
		logic [1:0] mode;     // operating mode
	} dct_cfg_t;

	// software write port for one timer's count bytes
	typedef struct packed {
		logic lowWrite;
		logic highWrite;
		logic [7:0] data;
	} dct_wr_t;
endpackage

// ==== rtl/dct_timer.sv ====
// dual counter/timer with prescaler, gating and overflow flags
`timescale 1ns/1ps
`default_nettype none
// Operation
// - internal timebase: system or prescaled clock
// - counter mode increments on pin falling edge
// - sixteen-bit count as low and high bytes
// - each timer has own independent mode bits
// - 13-bit: high byte plus low five bits
// - 13-bit wrap sets overflow flag, interrupt
// - counter-select picks pin or internal clock
// - clock-select: system clock or prescaled clock
// - count when run and gate condition allow
// - gate active level set by polarity bit
// - run does not reset count; preload first
// - second timer identical with own bits
// - 16-bit mode uses all sixteen bits
// - 8-bit reload: low counts, reload from high
// - overflow interrupt gated by own enable bit
// - flag holds until software or vector clears
module dct_timer #(
	parameter int DIV0 = 4,   // prescaled clock division, field value 0
	parameter int DIV1 = 12,  // field value 1
	parameter int DIV2 = 48,  // field value 2
	parameter int DIV3 = 8    // field value 3
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic [1:0] prescaleField,
	input wire dct_pkg::dct_cfg_t cfgA,
	input wire dct_pkg::dct_cfg_t cfgB,
	input wire dct_pkg::dct_wr_t wrA,
	input wire dct_pkg::dct_wr_t wrB,
	input wire logic flagAClear,
	input wire logic flagBClear,
	input wire logic timerACountPin,
	input wire logic timerBCountPin,
	input wire logic timerAGateInput,
	input wire logic timerBGateInput,
	output logic [7:0] timerALowByte,
	output logic [7:0] timerAHighByte,
	output logic [7:0] timerBLowByte,
	output logic [7:0] timerBHighByte,
	output logic timerAOverflowFlag,
	output logic timerBOverflowFlag,
	output logic timerAIrq,
	output logic timerBIrq,
	output logic splitModeA
);
	// refuse divisors that the 8-bit prescaler count cannot reach
	if (DIV0 < 1 || DIV1 < 1 || DIV2 < 1 || DIV3 < 1 ||
		DIV0 > 256 || DIV1 > 256 ||
		DIV2 > 256 || DIV3 > 256) begin : gDivCheck
		$error("prescale divisors must be 1..256");
	end

	// ==========================================================
	// prescaler
	logic [dct_pkg::PRESCALE_CNT_W-1:0] preCnt_r; // divider count
	logic [dct_pkg::PRESCALE_CNT_W-1:0] preTop;   // last count value
	logic preTick;                                // one-cycle enable

	// select the terminal count from the prescale field
	always_comb begin
		case (prescaleField)
			2'h0: preTop = 8'(DIV0 - 1);
			2'h1: preTop = 8'(DIV1 - 1);
			2'h2: preTop = 8'(DIV2 - 1);
			default: preTop = 8'(DIV3 - 1);
		endcase
	end

	assign preTick = (preCnt_r >= preTop);

	// free-running divider making the prescaled enable
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			preCnt_r <= '0;
		end else if (preTick) begin
			preCnt_r <= '0;
		end else begin
			preCnt_r <= preCnt_r + 8'h01;
		end
	end

	// ==========================================================
	// pin synchronisers: sync stage 0 feeds only stage 1
	logic [1:0] cntPinASync_r, cntPinBSync_r; // count pins
	logic [1:0] gateASync_r, gateBSync_r;     // gate inputs
	logic cntPinAPrev_r, cntPinBPrev_r;       // previous synced sample

	// two-flop synchronisers plus edge history
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			cntPinASync_r <= dct_pkg::SYNC_RESET;
			cntPinBSync_r <= dct_pkg::SYNC_RESET;
			gateASync_r <= dct_pkg::SYNC_RESET;
			gateBSync_r <= dct_pkg::SYNC_RESET;
			cntPinAPrev_r <= 1'b0;
			cntPinBPrev_r <= 1'b0;
		end else begin
			cntPinASync_r <= {cntPinASync_r[0], timerACountPin};
			cntPinBSync_r <= {cntPinBSync_r[0], timerBCountPin};
			gateASync_r <= {gateASync_r[0], timerAGateInput};
			gateBSync_r <= {gateBSync_r[0], timerBGateInput};
			cntPinAPrev_r <= cntPinASync_r[1];
			cntPinBPrev_r <= cntPinBSync_r[1];
		end
	end

	// falling edge: previous high, current low; one increment per edge
	logic fallA, fallB;
	assign fallA = cntPinAPrev_r & ~cntPinASync_r[1];
	assign fallB = cntPinBPrev_r & ~cntPinBSync_r[1];

	// ==========================================================
	// count enables
	logic tickA, tickB; // increment request this cycle

	// pick the source and apply run/gate qualification
	function automatic logic tick_of(input dct_pkg::dct_cfg_t c,
		input logic fall, input logic pre, input logic gate);
		logic src;
		logic gateOk;
		// pin edge, system clock, or prescaled enable
		src = c.counterSelect ? fall :
			(c.clockSelect ? 1'b1 : pre);
		gateOk = !c.gateEnable || (gate == c.gatePolarity);
		return c.run && gateOk && src;
	endfunction

	assign tickA = tick_of(cfgA, fallA, preTick, gateASync_r[1]);
	assign tickB = tick_of(cfgB, fallB, preTick, gateBSync_r[1]);

	// ==========================================================
	// count step per mode; returns {overflow, high, low}
	function automatic logic [16:0] step(input logic [1:0] mode,
		input logic [7:0] hi, input logic [7:0] lo);
		logic [13:0] c13;
		logic [16:0] c16;
		logic [8:0] c8;
		c13 = {1'b0, hi, lo[4:0]} + 14'h0001;
		c16 = {1'b0, hi, lo} + 17'h00001;
		c8 = {1'b0, lo} + 9'h001;
		case (mode)
			dct_pkg::MODE_13BIT: begin
				// upper low-byte bits are left as they are
				step = {c13[13], c13[12:5], lo[7:5], c13[4:0]};
			end
			dct_pkg::MODE_16BIT: begin
				step = c16;
			end
			dct_pkg::MODE_8RELOAD: begin
				// reload low from high on wrap; high untouched
				step = {c8[8], hi, (c8[8] ? hi : c8[7:0])};
			end
			default: begin
				// split mode is out of scope: count holds
				step = {1'b0, hi, lo};
			end
		endcase
	endfunction

	logic [16:0] nextA, nextB;
	assign nextA = step(cfgA.mode, timerAHighByte, timerALowByte);
	assign nextB = step(cfgB.mode, timerBHighByte, timerBLowByte);

	// ==========================================================
	// timer A count bytes; software write wins over a count step
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			{timerAHighByte, timerALowByte} <= dct_pkg::COUNT_RESET;
		end else begin
			// run bit never touches the count itself
			if (tickA) begin
				{timerAHighByte, timerALowByte} <= nextA[15:0];
			end
			if (wrA.lowWrite) begin
				timerALowByte <= wrA.data;
			end
			if (wrA.highWrite) begin
				timerAHighByte <= wrA.data;
			end
		end
	end

	// timer B count bytes, same behaviour
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			{timerBHighByte, timerBLowByte} <= dct_pkg::COUNT_RESET;
		end else begin
			if (tickB) begin
				{timerBHighByte, timerBLowByte} <= nextB[15:0];
			end
			if (wrB.lowWrite) begin
				timerBLowByte <= wrB.data;
			end
			if (wrB.highWrite) begin
				timerBHighByte <= wrB.data;
			end
		end
	end

	// ==========================================================
	// overflow flags: set wins over clear
	logic ovfA, ovfB;
	assign ovfA = tickA & nextA[16];
	assign ovfB = tickB & nextB[16];

	// sticky flags, cleared by software or interrupt vectoring
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			timerAOverflowFlag <= 1'b0;
			timerBOverflowFlag <= 1'b0;
		end else begin
			if (ovfA) begin
				timerAOverflowFlag <= 1'b1;
			end else if (flagAClear) begin
				timerAOverflowFlag <= 1'b0;
			end
			if (ovfB) begin
				timerBOverflowFlag <= 1'b1;
			end else if (flagBClear) begin
				timerBOverflowFlag <= 1'b0;
			end
		end
	end

	// registered interrupt requests and split-mode indication
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			timerAIrq <= 1'b0;
			timerBIrq <= 1'b0;
			splitModeA <= 1'b0;
		end else begin
			timerAIrq <= cfgA.irqEnable & (timerAOverflowFlag | ovfA) &
				~(flagAClear & ~ovfA);
			timerBIrq <= cfgB.irqEnable & (timerBOverflowFlag | ovfB) &
				~(flagBClear & ~ovfB);
			splitModeA <= (cfgA.mode == dct_pkg::MODE_SPLIT);
		end
	end
endmodule
`default_nettype wire

// ==== dv/dct_timer_props.sv ====
// port assertions and covers for the dual counter/timer
`timescale 1ns/1ps
`default_nettype none
module dct_timer_props (
	input wire logic mclk,
	input wire logic nrst,
	input wire dct_pkg::dct_cfg_t cfgA,
	input wire dct_pkg::dct_cfg_t cfgB,
	input wire dct_pkg::dct_wr_t wrA,
	input wire dct_pkg::dct_wr_t wrB,
	input wire logic flagAClear,
	input wire logic [7:0] timerALowByte,
	input wire logic [7:0] timerAHighByte,
	input wire logic [7:0] timerBLowByte,
	input wire logic [7:0] timerBHighByte,
	input wire logic timerAOverflowFlag,
	input wire logic timerAIrq,
	input wire logic splitModeA
);
	// ==========================================================
	// shorthands
	logic [15:0] cntA; // timer a count as one word
	logic [15:0] cntB; // timer b count as one word
	logic wA; // any software byte write on timer a
	logic wB; // any software byte write on timer b
	logic sysA; // timer a running free on the system clock
	assign cntA = {timerAHighByte, timerALowByte};
	assign cntB = {timerBHighByte, timerBLowByte};
	assign wA = wrA.lowWrite | wrA.highWrite;
	assign wB = wrB.lowWrite | wrB.highWrite;
	assign sysA = cfgA.run & ~cfgA.gateEnable & ~cfgA.counterSelect
		& cfgA.clockSelect;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);
	// ==========================================================
	// assertions
	sys_step_a: assert property (sysA && !wA
		&& cfgA.mode == dct_pkg::MODE_16BIT |=> cntA == $past(cntA) + 16'h1)
		else $error("count did not step on system clock");
	idle_hold_a: assert property (!cfgA.run && !wA |=> $stable(cntA))
		else $error("stopped timer a count moved");
	wrap16_a: assert property ($rose(timerAOverflowFlag) && !$past(wA)
		&& $past(cfgA.mode) == dct_pkg::MODE_16BIT |-> cntA == 16'h0)
		else $error("flag rose without 16-bit wrap");
	wrap13_a: assert property ($rose(timerAOverflowFlag) && !$past(wA)
		&& $past(cfgA.mode) == dct_pkg::MODE_13BIT
		|-> {timerAHighByte, timerALowByte[4:0]} == 13'h0)
		else $error("flag rose without 13-bit wrap");
	reload_a: assert property ($rose(timerAOverflowFlag) && !$past(wA)
		&& $past(cfgA.mode) == dct_pkg::MODE_8RELOAD
		|-> timerALowByte == timerAHighByte && $stable(timerAHighByte))
		else $error("low byte not reloaded from high byte");
	flag_keep_a: assert property (timerAOverflowFlag && !flagAClear
		|=> timerAOverflowFlag) else $error("overflow flag dropped by itself");
	irq_gate_a: assert property (timerAIrq
		|-> timerAOverflowFlag && $past(cfgA.irqEnable))
		else $error("irq without enabled flag");
	split_idle_a: assert property (cfgA.mode == dct_pkg::MODE_SPLIT
		&& !wA |=> $stable(cntA) && splitModeA)
		else $error("split mode not held idle");
	b_hold_a: assert property (!cfgB.run && !wB |=> $stable(cntB))
		else $error("stopped timer b count moved");
	// ==========================================================
	// covers
	cover property ($rose(timerAOverflowFlag));
	cover property (timerAIrq);
	cover property (splitModeA && cfgB.run);
endmodule
bind dct_timer dct_timer_props P (
	.mclk(mclk),
	.nrst(nrst),
	.cfgA(cfgA),
	.cfgB(cfgB),
	.wrA(wrA),
	.wrB(wrB),
	.flagAClear(flagAClear),
	.timerALowByte(timerALowByte),
	.timerAHighByte(timerAHighByte),
	.timerBLowByte(timerBLowByte),
	.timerBHighByte(timerBHighByte),
	.timerAOverflowFlag(timerAOverflowFlag),
	.timerAIrq(timerAIrq),
	.splitModeA(splitModeA)
);
`default_nettype wire

// ==== dv/dct_pin_model.sv ====
// model of the outside world: count pins and gate inputs
`timescale 1ns/1ps
`default_nettype none
module dct_pin_model (
	input wire logic mclk,
	input wire logic gateLvlA,
	output var logic pinA,
	output var logic pinB,
	output logic gateA,
	output logic gateB
);
	// count pins idle high, gate A follows the bench level, gate B held low
	initial begin
		pinA = 1'h1;
		pinB = 1'h1;
	end
	assign gateA = gateLvlA;
	assign gateB = 1'h0;
	// n falling edges, each level held three clocks
	task automatic pulse(input int n);
		repeat (n) begin
			repeat (3) @(posedge mclk);
			#2 pinA = 1'h0;
			repeat (3) @(posedge mclk);
			#2 pinA = 1'h1;
		end
	endtask
endmodule
`default_nettype wire

// ==== dv/dual_counter_timer_bench.sv ====
// self-checking bench for the dual counter/timer
`timescale 1ns/1ps
`default_nettype none
module dual_counter_timer_bench;
	// ==========================================================
	// signals
	typedef struct {int sel; logic [15:0] v;} dct_exp_t;
	localparam int DV[4] = '{4, 12, 48, 8}; // prescaled divisors
	logic mclk = 1'h0;
	logic nrst = 1'h0;
	logic [1:0] psf = 2'h0;
	dct_pkg::dct_cfg_t cfgA = 8'h00;
	dct_pkg::dct_cfg_t cfgB = 8'h00;
	dct_pkg::dct_wr_t wrA = 10'h000;
	dct_pkg::dct_wr_t wrB = 10'h000;
	logic clrA = 1'h0;
	logic clrB = 1'h0; // software clear of timer b flag
	logic gA = 1'h0;
	logic pinA, pinB, gateA, gateB, fA, fB, iA, iB, sA;
	logic [7:0] aLo, aHi, bLo, bHi;
	dct_exp_t q[$]; // expected results, oldest first
	dct_exp_t e;
	event doChk;
	int failCount = 0;
	int checked = 0;
	int cycles = 0;
	int n;
	always #12.5 mclk = ~mclk;
	dct_timer #(.DIV0(DV[0]), .DIV1(DV[1]), .DIV2(DV[2]), .DIV3(DV[3])) DUT (
		.mclk(mclk), .nrst(nrst), .prescaleField(psf), .cfgA(cfgA),
		.cfgB(cfgB), .wrA(wrA), .wrB(wrB), .flagAClear(clrA),
		.flagBClear(clrB), .timerACountPin(pinA), .timerBCountPin(pinB),
		.timerAGateInput(gateA), .timerBGateInput(gateB),
		.timerALowByte(aLo), .timerAHighByte(aHi), .timerBLowByte(bLo),
		.timerBHighByte(bHi), .timerAOverflowFlag(fA),
		.timerBOverflowFlag(fB), .timerAIrq(iA), .timerBIrq(iB),
		.splitModeA(sA));
	dct_pin_model PM (.mclk(mclk), .gateLvlA(gA), .pinA(pinA),
		.pinB(pinB), .gateA(gateA), .gateB(gateB));
	// ==========================================================
	// checking
	task automatic cmp16(input int s, input logic [15:0] x, input logic [15:0] y);
		checked++;
		if (y !== x) begin
			failCount++;
			$display("wrong value count%0d exp %h seen %h", s, x, y);
		end
	endtask
	task automatic cmp1(input int s, input logic x, input logic y);
		checked++;
		if (y !== x) begin
			failCount++;
			$display("wrong value bit%0d exp %b seen %b", s, x, y);
		end
	endtask
	// watcher: oldest note against the outputs
	always @(doChk) while (q.size() > 0) begin
		e = q.pop_front();
		case (e.sel)
			0: cmp16(0, e.v, {aHi, aLo});
			1: cmp16(1, e.v, {aHi, 3'h0, aLo[4:0]});
			2: cmp16(2, e.v, {bHi, bLo});
			3: cmp1(3, e.v[0], fA);
			4: cmp1(4, e.v[0], iA);
			5: cmp1(5, e.v[0], sA);
			6: cmp1(6, e.v[0], fB);
			default: cmp1(7, e.v[0], iB);
		endcase
	end
	task automatic note(input int s, input logic [15:0] v);
		q.push_back('{s, v});
		->doChk;
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge mclk);
		#2;
	endtask
	// loads timer a, low byte then high byte
	task automatic ldA(input logic [7:0] hi, input logic [7:0] lo);
		wrA = {2'h2, lo};
		cyc(1);
		wrA = {2'h1, hi};
		cyc(1);
		wrA = 10'h000;
	endtask
	task automatic wrapUp();
		$display("checks %0d mismatches %0d", checked, failCount);
		if (failCount == 0 && checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// hang guard
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 8000) begin
			failCount++;
			wrapUp();
		end
	end
	// ==========================================================
	// tests; cfg bits: run gate ctr sys pol irq mode[1:0]
	initial begin
		n = $urandom(70738);
		cyc(6);
		nrst = 1'h1;
		cyc(1);
		ldA(8'hFF, 8'hFE);
		cfgA = 8'h95;
		cyc(1); note(0, 16'hFFFF);
		cyc(1); note(0, 16'h0000);
		note(3, 16'h0001);
		cyc(1); note(4, 16'h0001);
		clrA = 1'h1; cyc(1); clrA = 1'h0; cfgA = 8'h00; cyc(1);
		note(3, 16'h0000);
		ldA(8'hFF, 8'hFF);
		cfgA = 8'h90;
		cyc(1); cfgA = 8'h00; note(1, 16'h0000);
		cyc(1); note(4, 16'h0000);
		clrA = 1'h1;
		n = $urandom_range(255);
		ldA(n[7:0], 8'hFE);
		clrA = 1'h0;
		cfgA = 8'h92;
		cyc(2); cfgA = 8'h00; note(0, {n[7:0], n[7:0]});
		$display("test wrap modes done");
		for (int f = 0; f < 4; f++) begin
			psf = f[1:0];
			cyc(260);
			ldA(8'h00, 8'h00);
			cfgA = 8'h81;
			cyc(3 * DV[f]); cfgA = 8'h00; cyc(2);
			note(0, 16'h0003);
		end
		$display("test prescaler done");
		for (int p = 0; p < 2; p++) begin
			ldA(8'h00, 8'h00);
			n = $urandom_range(8, 1);
			gA = 1'($urandom_range(1));
			cfgA = p ? 8'hE9 : 8'hE1;
			cyc(4); PM.pulse(n); cyc(6); cfgA = 8'h00;
			note(0, (gA == p[0]) ? n[15:0] : 16'h0000);
		end
		$display("test pins and gate done");
		ldA(8'h12, 8'h34);
		wrB = {2'h2, 8'hFE}; cyc(1); wrB = {2'h1, 8'hFF}; cyc(1); wrB = 10'h000;
		cfgA = 8'h83; cfgB = 8'h95;
		cyc(5); cfgB = 8'h00; cfgA = 8'h00;
		note(2, 16'h0003);
		note(0, 16'h1234);
		note(5, 16'h0001);
		note(6, 16'h0001);
		note(7, 16'h0001);
		clrB = 1'h1;
		cyc(1);
		clrB = 1'h0;
		note(6, 16'h0000);
		note(7, 16'h0000);
		$display("test second timer done");
		cyc(2);
		wrapUp();
	end
endmodule
`default_nettype wire
